// ===== usb_gen_cmd_pkg.sv
// Shared constants and decoders for the general-command register set
package usb_gen_cmd_pkg;

    localparam logic [7:0]  CMD_UNLOCK      = 8'hb0;
    localparam logic [7:0]  CMD_SCRATCH_WR  = 8'hb2;
    localparam logic [7:0]  CMD_SCRATCH_RD  = 8'hb3;
    localparam logic [7:0]  CMD_FRAME_RD    = 8'hb4;
    localparam logic [7:0]  CMD_PART_RD     = 8'hb5;
    localparam logic [7:0]  CMD_IRQ_RD      = 8'hc0;
    localparam logic [15:0] UNLOCK_KEY      = 16'haa37;
    localparam logic [14:0] SCRATCH_RESET   = 15'h0000;
    localparam logic [31:0] IRQ_RESET       = 32'h0000_0000;
    localparam logic [10:0] FRAME_RESET     = 11'h000;
    // Bits 0,1,3,4,6 self-clear when the register is read
    localparam logic [31:0] IRQ_READ_CLEAR  = 32'h0000_005b;
    localparam int          IRQ_BUS_STATE   = 7;
    localparam int          IRQ_EP_LSB      = 8;
    localparam int          IRQ_EP_MSB      = 23;
    localparam int          SCRATCH_WIDTH   = 15;
    localparam int          FRAME_WIDTH     = 11;

    // Data phases a command carries: bytes on 8-bit, words on 16-bit
    function automatic logic [2:0] phase_count(input logic [7:0] cmd, input logic wide);
        logic [2:0] n;
        n = 3'h0;
        case (cmd)
            CMD_UNLOCK, CMD_SCRATCH_WR, CMD_SCRATCH_RD,
            CMD_FRAME_RD, CMD_PART_RD: n = wide ? 3'h1 : 3'h2;
            CMD_IRQ_RD:                n = wide ? 3'h2 : 3'h4;
            default:                   n = 3'h0;
        endcase
        return n;
    endfunction

    function automatic logic is_write_cmd(input logic [7:0] cmd);
        return (cmd == CMD_UNLOCK) || (cmd == CMD_SCRATCH_WR);
    endfunction

endpackage

// ===== usb_cmd_port_if.sv
// Parallel command/data port between microcontroller and controller
`timescale 1ns/1ps
interface usb_cmd_port_if;
    logic        command_data_select;
    logic        wr_strobe;
    logic        rd_strobe;
    logic [15:0] host_data;
    logic [15:0] dev_data;
    logic        dev_valid;

    modport device (
        input  command_data_select,
        input  wr_strobe,
        input  rd_strobe,
        input  host_data,
        output dev_data,
        output dev_valid
    );

    modport host (
        output command_data_select,
        output wr_strobe,
        output rd_strobe,
        output host_data,
        input  dev_data,
        input  dev_valid
    );
endinterface

// ===== usb_gen_cmd_device.sv
// Controller end: general-command register set behind the command port
`timescale 1ns/1ps
module usb_gen_cmd_device
    import usb_gen_cmd_pkg::*;
#(
    parameter logic [7:0] PART_CODE       = 8'h5a,  // Arbitrary value
    parameter logic [7:0] SILICON_VERSION = 8'h10   // Arbitrary value
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Command port
    usb_cmd_port_if.device   port,
    // Bus width strap, 1 = 16-bit
    input  wire logic        bus_wide,
    // USB engine events and state
    input  wire logic        bus_suspended_state,
    input  wire logic        sof_good,
    input  wire logic [10:0] sof_frame,
    input  wire logic [6:0]  low_events,
    input  wire logic [15:0] endpoint_events,
    input  wire logic [15:0] endpoint_status_read,
    // Visible state
    output logic [31:0]      interrupt_sources,
    output logic [14:0]      scratch_word,
    output logic             write_locked
);

    logic [7:0]  cmd_r;
    logic [2:0]  phase_r;
    logic [7:0]  key_low_r;
    logic [31:0] snap_r;
    logic [31:0] irq_r;
    logic [14:0] scratch_r;
    logic [10:0] frame_r;
    logic        locked_r;
    logic [15:0] rdata_r;
    logic        rvalid_r;

    logic        cmd_wr;
    logic        data_wr;
    logic        data_rd;
    logic        in_range;
    logic        commit;
    logic [15:0] commit_val;
    logic        irq_read;
    logic [31:0] irq_live;

    ////////////////////////////////////////////////////////////////////////////
    // Phase decode

    assign cmd_wr   = port.wr_strobe && port.command_data_select;
    assign data_wr  = port.wr_strobe && !port.command_data_select;
    assign data_rd  = port.rd_strobe && !port.command_data_select;
    assign in_range = phase_r < phase_count(cmd_r, bus_wide);

    // Completed write value: whole word, or last byte over stored low byte
    assign commit = data_wr && in_range && is_write_cmd(cmd_r)
                    && (bus_wide || phase_r == 3'h1);
    assign commit_val = bus_wide ? port.host_data
                                 : {port.host_data[7:0], key_low_r};

    // A locked device does not clear anything on a refused read
    assign irq_read = cmd_wr && (port.host_data[7:0] == CMD_IRQ_RD) && !locked_r;

    always_comb begin
        irq_live = irq_r;
        irq_live[IRQ_BUS_STATE] = bus_suspended_state;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cmd_r   <= 8'h00;
            phase_r <= 3'h0;
        end else if (cmd_wr) begin
            cmd_r   <= port.host_data[7:0];
            phase_r <= 3'h0;
        end else if ((data_wr || data_rd) && in_range) begin
            phase_r <= phase_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            key_low_r <= 8'h00;
        end else if (data_wr && !bus_wide && phase_r == 3'h0) begin
            key_low_r <= port.host_data[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write protection

    // Suspend wins over the key in the same cycle, so the lock cannot be lost
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            locked_r <= 1'b0;
        end else if (bus_suspended_state) begin
            locked_r <= 1'b1;
        end else if (commit && cmd_r == CMD_UNLOCK && commit_val == UNLOCK_KEY) begin
            locked_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scratch and frame number

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            scratch_r <= SCRATCH_RESET;
        end else if (commit && cmd_r == CMD_SCRATCH_WR && !locked_r) begin
            scratch_r <= commit_val[SCRATCH_WIDTH-1:0];
        end
    end

    // Bus reset leaves the old count; it is meaningless until the next frame
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            frame_r <= FRAME_RESET;
        end else if (sof_good) begin
            frame_r <= sof_frame;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt sources

    // Logged with no regard to enables; a new event beats a same-cycle clear
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_irq
            if (gi < IRQ_BUS_STATE) begin : g_low
                always_ff @(posedge clk_sys) begin
                    if (!rst_n) begin
                        irq_r[gi] <= IRQ_RESET[gi];
                    end else if (low_events[gi]) begin
                        irq_r[gi] <= 1'b1;
                    end else if (irq_read && IRQ_READ_CLEAR[gi]) begin
                        irq_r[gi] <= 1'b0;
                    end
                end
            end else if (gi >= IRQ_EP_LSB && gi <= IRQ_EP_MSB) begin : g_ep
                always_ff @(posedge clk_sys) begin
                    if (!rst_n) begin
                        irq_r[gi] <= IRQ_RESET[gi];
                    end else if (endpoint_events[gi-IRQ_EP_LSB]) begin
                        irq_r[gi] <= 1'b1;
                    end else if (endpoint_status_read[gi-IRQ_EP_LSB]) begin
                        irq_r[gi] <= 1'b0;
                    end
                end
            end else begin : g_rsv
                assign irq_r[gi] = 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read snapshot and answer

    // Snapshot at the command so multi-byte reads are self-consistent
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            snap_r <= 32'h0000_0000;
        end else if (cmd_wr) begin
            case (port.host_data[7:0])
                CMD_SCRATCH_RD: snap_r <= {17'h00000, scratch_r};
                CMD_FRAME_RD:   snap_r <= {21'h000000, frame_r};
                CMD_PART_RD:    snap_r <= {16'h0000, PART_CODE, SILICON_VERSION};
                CMD_IRQ_RD:     snap_r <= irq_live;
                default:        snap_r <= 32'h0000_0000;
            endcase
        end
    end

    // Locked, out of range or write-only reads answer zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= data_rd;
            if (!data_rd || !in_range || locked_r || is_write_cmd(cmd_r)) begin
                rdata_r <= 16'h0000;
            end else if (bus_wide) begin
                rdata_r <= phase_r[0] ? snap_r[31:16] : snap_r[15:0];
            end else begin
                case (phase_r[1:0])
                    2'h0:    rdata_r <= {8'h00, snap_r[7:0]};
                    2'h1:    rdata_r <= {8'h00, snap_r[15:8]};
                    2'h2:    rdata_r <= {8'h00, snap_r[23:16]};
                    default: rdata_r <= {8'h00, snap_r[31:24]};
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            interrupt_sources <= IRQ_RESET;
            scratch_word      <= SCRATCH_RESET;
            write_locked      <= 1'b0;
        end else begin
            interrupt_sources <= irq_live;
            scratch_word      <= scratch_r;
            write_locked      <= locked_r;
        end
    end

    assign port.dev_data  = rdata_r;
    assign port.dev_valid = rvalid_r;

endmodule

// ===== usb_gen_cmd_host.sv
// Microcontroller end: issues one general command and its data phases
`timescale 1ns/1ps
module usb_gen_cmd_host
    import usb_gen_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Command port
    usb_cmd_port_if.host     port,
    // Bus width strap, 1 = 16-bit
    input  wire logic        bus_wide,
    // User request
    input  wire logic        start,
    input  wire logic [7:0]  command,
    input  wire logic [15:0] write_value,
    input  wire logic        frame_one_byte,
    // User answer
    output logic [31:0]      read_value,
    output logic             done,
    output logic             busy
);

    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_DATA, ST_WAIT, ST_DONE} host_state_e;

    host_state_e state_r;
    logic [7:0]  cmd_r;
    logic [15:0] wval_r;
    logic [2:0]  total_r;
    logic [2:0]  phase_r;
    logic [31:0] rval_r;
    logic        sel_r;
    logic        wr_r;
    logic        rd_r;
    logic [15:0] hdata_r;
    logic [2:0]  total_nxt;

    // Frame number may stop after the low byte on an 8-bit bus
    always_comb begin
        total_nxt = phase_count(command, bus_wide);
        if (command == CMD_FRAME_RD && frame_one_byte && !bus_wide) begin
            total_nxt = 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cmd_r   <= 8'h00;
            wval_r  <= 16'h0000;
            total_r <= 3'h0;
            phase_r <= 3'h0;
            rval_r  <= 32'h0000_0000;
            sel_r   <= 1'b0;
            wr_r    <= 1'b0;
            rd_r    <= 1'b0;
            hdata_r <= 16'h0000;
        end else begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            case (state_r)
                ST_IDLE: if (start) begin
                    cmd_r   <= command;
                    // Reserved scratch bit always goes out as zero
                    wval_r  <= (command == CMD_SCRATCH_WR) ? {1'b0, write_value[14:0]}
                                                           : write_value;
                    total_r <= total_nxt;
                    phase_r <= 3'h0;
                    rval_r  <= 32'h0000_0000;
                    state_r <= ST_CMD;
                end
                ST_CMD: begin
                    sel_r   <= 1'b1;
                    wr_r    <= 1'b1;
                    hdata_r <= {8'h00, cmd_r};
                    state_r <= (total_r == 3'h0) ? ST_DONE : ST_DATA;
                end
                ST_DATA: begin
                    sel_r <= 1'b0;
                    if (is_write_cmd(cmd_r)) begin
                        wr_r    <= 1'b1;
                        hdata_r <= bus_wide ? wval_r
                                 : (phase_r[0] ? {8'h00, wval_r[15:8]}
                                               : {8'h00, wval_r[7:0]});
                        phase_r <= phase_r + 3'h1;
                        state_r <= (phase_r + 3'h1 == total_r) ? ST_DONE : ST_DATA;
                    end else begin
                        rd_r    <= 1'b1;
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: if (port.dev_valid) begin
                    // Low part first, packed upward
                    if (bus_wide) begin
                        if (phase_r[0]) rval_r[31:16] <= port.dev_data;
                        else            rval_r[15:0]  <= port.dev_data;
                    end else begin
                        case (phase_r[1:0])
                            2'h0:    rval_r[7:0]   <= port.dev_data[7:0];
                            2'h1:    rval_r[15:8]  <= port.dev_data[7:0];
                            2'h2:    rval_r[23:16] <= port.dev_data[7:0];
                            default: rval_r[31:24] <= port.dev_data[7:0];
                        endcase
                    end
                    phase_r <= phase_r + 3'h1;
                    state_r <= (phase_r + 3'h1 == total_r) ? ST_DONE : ST_DATA;
                end
                ST_DONE: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            read_value <= 32'h0000_0000;
            done       <= 1'b0;
            busy       <= 1'b0;
        end else begin
            done <= (state_r == ST_DONE);
            busy <= (state_r != ST_IDLE) || start;
            if (state_r == ST_DONE) begin
                read_value <= rval_r;
            end
        end
    end

    assign port.command_data_select = sel_r;
    assign port.wr_strobe           = wr_r;
    assign port.rd_strobe           = rd_r;
    assign port.host_data           = hdata_r;

endmodule

// ===== usb_gen_cmd_checker.sv
// Concurrent checks on the command port between host and device ends
`timescale 1ns/1ps
module usb_gen_cmd_checker
    import usb_gen_cmd_pkg::*;
#(
    parameter logic [7:0] PART_CODE       = 8'h5a,
    parameter logic [7:0] SILICON_VERSION = 8'h10
) (
    // Clock, reset and strap
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        bus_wide,
    // Port signals
    input wire logic        command_data_select,
    input wire logic        wr_strobe,
    input wire logic        rd_strobe,
    input wire logic [15:0] host_data,
    input wire logic [15:0] dev_data,
    input wire logic        dev_valid
);
    logic [7:0] cmd_r;
    logic [2:0] idx_r;
    logic [2:0] ans_r;
    logic [2:0] lim;
    logic       cmd_wr;
    logic       data_rd;

    assign cmd_wr  = wr_strobe && command_data_select;
    assign data_rd = rd_strobe && !command_data_select;
    assign lim     = (cmd_r == CMD_IRQ_RD) ? (bus_wide ? 3'h2 : 3'h4) : (bus_wide ? 3'h1 : 3'h2);

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            cmd_r <= 8'h00;
        else if (cmd_wr)
            cmd_r <= host_data[7:0];
    end

    // Saturates so a runaway host never wraps back into a valid phase
    always_ff @(posedge clk_sys) begin
        if (!rst_n || cmd_wr)
            idx_r <= 3'h0;
        else if ((data_rd || wr_strobe) && idx_r != 3'h7)
            idx_r <= idx_r + 3'h1;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            ans_r <= 3'h0;
        else if (data_rd)
            ans_r <= idx_r;
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    answer_follows_read_a: assert property (data_rd |=> dev_valid)
        else $error("no answer one cycle after a data read");
    answer_has_cause_a: assert property (dev_valid |-> $past(data_rd))
        else $error("answer without a data read");
    idle_data_zero_a: assert property (!dev_valid |-> dev_data == 16'h0000)
        else $error("data driven while not answering");
    part_code_a: assert property (dev_valid && cmd_r == CMD_PART_RD |-> dev_data ==
        (ans_r == 3'h0 ? (bus_wide ? {PART_CODE, SILICON_VERSION} : {8'h00, SILICON_VERSION}) :
        (ans_r == 3'h1 && !bus_wide) ? {8'h00, PART_CODE} : 16'h0000))
        else $error("identity bytes wrong");
    excess_phase_a: assert property (dev_valid && ans_r >= lim |-> dev_data == 16'h0000)
        else $error("extra data phase answered with data");
    irq_reserved_a: assert property (dev_valid && cmd_r == CMD_IRQ_RD &&
        ans_r == (bus_wide ? 3'h1 : 3'h3) |-> (dev_data & 16'hff00) == 16'h0000 &&
        (bus_wide || dev_data[7:0] == 8'h00))
        else $error("reserved interrupt bits not zero");
    frame_reserved_a: assert property (dev_valid && cmd_r == CMD_FRAME_RD &&
        ans_r == (bus_wide ? 3'h0 : 3'h1) |->
        (dev_data & (bus_wide ? 16'hf800 : 16'h00f8)) == 16'h0000)
        else $error("reserved frame bits not zero");
    command_no_read_a: assert property (!(rd_strobe && command_data_select))
        else $error("read strobe in command phase");
    irq_read_whole_a: assert property (cmd_wr && cmd_r == CMD_IRQ_RD |->
        idx_r == (bus_wide ? 3'h2 : 3'h4))
        else $error("interrupt register not read whole");

    cover property (cmd_wr && host_data[7:0] == CMD_IRQ_RD);
    cover property (cmd_wr && host_data[7:0] == CMD_UNLOCK);
    cover property (dev_valid && bus_wide);
endmodule

// ===== tb.sv
// Testbench joining host and device ends across the command port
`timescale 1ns/1ps
module tb
    import usb_gen_cmd_pkg::*;
;
    localparam logic [7:0] PART_ID    = 8'h3c;  // Arbitrary value
    localparam logic [7:0] VERSION_ID = 8'h25;  // Arbitrary value

    typedef struct {
        logic [7:0]  cmd;
        logic [15:0] wv;
        logic        one;
        logic        chk;
        logic [31:0] exp;
    } row_s;

    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        bus_wide = 1'b0;
    logic        bus_suspended_state = 1'b0;
    logic        sof_good = 1'b0;
    logic [10:0] sof_frame = 11'h000;
    logic [6:0]  low_events = 7'h00;
    logic [15:0] endpoint_events = 16'h0000;
    logic [15:0] endpoint_status_read = 16'h0000;
    logic        start = 1'b0;
    logic [7:0]  command = 8'h00;
    logic [15:0] write_value = 16'h0000;
    logic        frame_one_byte = 1'b0;
    logic [31:0] read_value;
    logic        done;
    logic        busy;
    logic [31:0] interrupt_sources;
    logic [14:0] scratch_word;
    logic        write_locked;
    int          mismatches = 0;
    int          checks = 0;

    always #10 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    usb_cmd_port_if usb_cmd_port_if_i ();

    usb_gen_cmd_device #(.PART_CODE(PART_ID), .SILICON_VERSION(VERSION_ID)) usb_gen_cmd_device_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .port(usb_cmd_port_if_i.device), .bus_wide(bus_wide),
        .bus_suspended_state(bus_suspended_state), .sof_good(sof_good), .sof_frame(sof_frame),
        .low_events(low_events), .endpoint_events(endpoint_events),
        .endpoint_status_read(endpoint_status_read), .interrupt_sources(interrupt_sources),
        .scratch_word(scratch_word), .write_locked(write_locked));

    usb_gen_cmd_host usb_gen_cmd_host_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .port(usb_cmd_port_if_i.host), .bus_wide(bus_wide),
        .start(start), .command(command), .write_value(write_value),
        .frame_one_byte(frame_one_byte), .read_value(read_value), .done(done), .busy(busy));

    usb_gen_cmd_checker #(.PART_CODE(PART_ID), .SILICON_VERSION(VERSION_ID))
        usb_gen_cmd_checker_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .bus_wide(bus_wide),
        .command_data_select(usb_cmd_port_if_i.command_data_select),
        .wr_strobe(usb_cmd_port_if_i.wr_strobe), .rd_strobe(usb_cmd_port_if_i.rd_strobe),
        .host_data(usb_cmd_port_if_i.host_data), .dev_data(usb_cmd_port_if_i.dev_data),
        .dev_valid(usb_cmd_port_if_i.dev_valid));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_for(input logic want_done);
        int n;
        n = 0;
        while ((want_done ? done : !busy) !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 40) begin
            mismatches++;
            $display("wrong value handshake expected %b seen timeout", want_done);
            close_out();
        end
    endtask

    // Waits for idle first: start is dropped while the host is busy
    task automatic run(input logic [7:0] cmd, input logic [15:0] wv, input logic one);
        wait_for(1'b0);
        command = cmd;
        write_value = wv;
        frame_one_byte = one;
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        wait_for(1'b1);
        @(negedge clk_sys);
    endtask

    task automatic pulse(input logic [6:0] le, input logic [15:0] ee, input logic [15:0] er,
                         input logic sg, input logic [10:0] f);
        @(negedge clk_sys);
        {low_events, endpoint_events, endpoint_status_read, sof_good, sof_frame} =
            {le, ee, er, sg, f};
        @(negedge clk_sys);
        {low_events, endpoint_events, endpoint_status_read, sof_good} = '0;
        repeat (2) @(negedge clk_sys);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        row_s rows [0:7];
        rows = '{
            '{CMD_SCRATCH_RD, 16'h0000, 1'b0, 1'b1, 32'h0000_0000},
            '{CMD_SCRATCH_WR, 16'hffff, 1'b0, 1'b0, 32'h0000_0000},
            '{CMD_SCRATCH_RD, 16'h0000, 1'b0, 1'b1, 32'h0000_7fff},
            '{CMD_SCRATCH_WR, 16'h1234, 1'b0, 1'b0, 32'h0000_0000},
            '{CMD_SCRATCH_RD, 16'h0000, 1'b0, 1'b1, 32'h0000_1234},
            '{CMD_FRAME_RD,   16'h0000, 1'b0, 1'b1, 32'h0000_05a3},
            '{CMD_FRAME_RD,   16'h0000, 1'b1, 1'b1, 32'h0000_00a3},
            '{CMD_PART_RD,    16'h0000, 1'b0, 1'b1, {16'h0000, PART_ID, VERSION_ID}}};
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        check("write_locked", 32'h0, {31'h0, write_locked});
        check("interrupt_sources", 32'h0, interrupt_sources);
        pulse(7'h00, 16'h0000, 16'h0000, 1'b1, 11'h5a3);
        foreach (rows[i]) begin
            run(rows[i].cmd, rows[i].wv, rows[i].one);
            if (rows[i].chk)
                check("read_value", rows[i].exp, read_value);
        end
        // Events, clear on read, endpoint clear
        pulse(7'h7f, 16'hffff, 16'h0000, 1'b0, 11'h000);
        run(CMD_IRQ_RD, 16'h0000, 1'b0);
        check("irq all", 32'h00ff_ff7f, read_value);
        run(CMD_IRQ_RD, 16'h0000, 1'b0);
        check("irq after read", 32'h00ff_ff24, read_value);
        pulse(7'h00, 16'h0000, 16'h0002, 1'b0, 11'h000);
        run(CMD_IRQ_RD, 16'h0000, 1'b0);
        check("irq endpoint clear", 32'h00ff_fd24, read_value);
        // Suspend lock, wrong key, right key
        bus_suspended_state = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("bus state bit", 32'h1, {31'h0, interrupt_sources[7]});
        check("write_locked", 32'h1, {31'h0, write_locked});
        run(CMD_IRQ_RD, 16'h0000, 1'b0);
        check("locked read", 32'h0, read_value);
        bus_suspended_state = 1'b0;
        run(CMD_SCRATCH_WR, 16'h0555, 1'b0);
        run(CMD_UNLOCK, 16'haa36, 1'b0);
        check("write_locked", 32'h1, {31'h0, write_locked});
        run(CMD_UNLOCK, 16'haa37, 1'b0);
        check("write_locked", 32'h0, {31'h0, write_locked});
        check("scratch_word", 32'h1234, {17'h0, scratch_word});
        run(CMD_IRQ_RD, 16'h0000, 1'b0);
        check("irq kept", 32'h00ff_fd24, read_value);
        // Second reset into 16-bit mode
        @(negedge clk_sys);
        rst_n = 1'b0;
        bus_wide = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        pulse(7'h00, 16'h0000, 16'h0000, 1'b1, 11'h7ff);
        run(CMD_FRAME_RD, 16'h0000, 1'b0);
        check("wide frame", 32'h0000_07ff, read_value);
        run(CMD_SCRATCH_WR, 16'h8abc, 1'b0);
        run(CMD_SCRATCH_RD, 16'h0000, 1'b0);
        check("wide scratch", 32'h0000_0abc, read_value);
        pulse(7'h01, 16'h4000, 16'h0000, 1'b0, 11'h000);
        run(CMD_IRQ_RD, 16'h0000, 1'b0);
        check("wide irq", 32'h0040_0001, read_value);
        run(CMD_PART_RD, 16'h0000, 1'b0);
        check("wide part", {16'h0000, PART_ID, VERSION_ID}, read_value);
        // Wide lock: write dropped, then the key as one word
        bus_suspended_state = 1'b1;
        repeat (2) @(negedge clk_sys);
        bus_suspended_state = 1'b0;
        run(CMD_SCRATCH_WR, 16'h0123, 1'b0);
        check("write_locked", 32'h1, {31'h0, write_locked});
        run(CMD_UNLOCK, 16'haa37, 1'b0);
        check("write_locked", 32'h0, {31'h0, write_locked});
        check("scratch_word", 32'h0abc, {17'h0, scratch_word});
        close_out();
    end
endmodule
